// [isr_top.v]
// Contract
// - Front panel request appears as master request bit 4 while pending.
// - Front panel request reaches processor only while master mask bit 4 is low.
// - Writing 00h drives LED-off line low; later nonzero write raises it, raising panel request.
// - Host writes 04h, 22h, then E0h thirty-three times to clear panel request.
// - Serial request appears as first slave request bit 4.
// - Serial request passes only while master bit 1 and slave1 bit 4 masks low.
// - Control latch bits 3 and 4 hold serial receiver and transmitter in reset.
// - Control select 38h gives loopback; output mask 00h suppresses all serial requests.
// - Output mask 01h enables transmitter-empty request, asserted while transmitter is empty.
// - Serial status shows left, centre, right data-back in bits 5, 3, 0.
// - Writing 00h to clock mask register masks every clock source.
// - Reading clock status register clears all its pending interrupts.
// - Clock request appears as third slave request bit 6.
// - Clock request passes only while slave3 bit 6 and master bit 3 masks low.
// - Command 18h with mask 02h fires hundredth-second interrupt within 10 ms.
// - Command 08h stops hundredth-second interrupt generation.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "isr_map.vh"

module isr_top #(
    parameter TICK_CYCLES = `ISR_RTC_TICK_CYC
) (
    // Clock and reset.
    input  wire        CLK_I,
    input  wire        RST_N_I,
    // Avalon-MM slave.
    input  wire [5:0]  AVS_ADDRESS_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    output wire [31:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    // Serial link port pins.
    input  wire [2:0]  SERIAL_LINK_PORT_DATA_BACK_I,
    input  wire [2:0]  SERIAL_LINK_PORT_EVENT_I,
    output wire        SERIAL_LINK_PORT_RX_RESET_O,
    output wire        SERIAL_LINK_PORT_TX_RESET_O,
    output wire        SERIAL_LINK_PORT_LOOPBACK_O,
    // Front panel.
    output wire        INFRARED_LED_OFF_N_O,
    // Processor interrupt.
    output wire        CPU_INT_O
);

    // ****************************************************************
    // Front panel command sequence states
    // ****************************************************************
    localparam FP_IDLE  = 4'b0001;
    localparam FP_GOT_A = 4'b0010;
    localparam FP_GOT_B = 4'b0100;
    localparam FP_COUNT = 4'b1000;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [7:0]  master_mask;
    reg  [7:0]  slave1_mask;
    reg  [7:0]  slave3_mask;
    reg  [7:0]  fp_cmd;
    reg  [7:0]  ir_dis;
    reg  [7:0]  misc_ctrl;
    reg  [7:0]  ser_ctrl;
    reg  [7:0]  ser_imask;
    reg  [7:0]  rtc_cmd;
    reg  [7:0]  rtc_mask;
    reg  [7:0]  rtc_status;
    reg         fp_pending;
    reg  [3:0]  fp_state;
    reg  [3:0]  next_fp_state;
    reg  [5:0]  fp_count;
    reg  [5:0]  next_fp_count;
    reg         fp_clear;
    reg  [31:0] tick_count;
    reg         tick;
    reg         ack;
    reg  [31:0] rdata;
    reg  [31:0] next_rdata;
    wire [2:0]  data_back;
    wire [2:0]  ser_ext;
    wire        bus_req;
    wire        accept;
    wire        wr_en;
    wire        rd_en;
    wire [3:0]  reg_sel;
    wire [7:0]  wbyte;
    wire        rx_reset;
    wire        tx_reset;
    wire        tx_empty;
    wire [3:0]  ser_events;
    wire        ser_req;
    wire        rtc_req;
    wire [7:0]  slave1_req;
    wire [7:0]  slave3_req;
    wire        slave1_out;
    wire        slave3_out;
    wire [7:0]  master_req;
    wire [7:0]  ser_status;
    wire        ir_rise;
    wire        tick_run;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    isr_sync #(
        .WIDTH (6)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_n_i (RST_N_I),
        .async_i ({SERIAL_LINK_PORT_EVENT_I, SERIAL_LINK_PORT_DATA_BACK_I}),
        .sync_o  ({ser_ext, data_back})
    );

    // ****************************************************************
    // Avalon-MM slave
    // ****************************************************************
    // One wait state lets read data settle in a flop before the master samples it.
    assign bus_req           = AVS_READ_I | AVS_WRITE_I;
    assign accept            = bus_req & ack;
    assign wr_en             = accept & AVS_WRITE_I;
    assign rd_en             = accept & AVS_READ_I;
    assign reg_sel           = AVS_ADDRESS_I[5:2];
    assign wbyte             = AVS_WRITEDATA_I[7:0];
    assign AVS_WAITREQUEST_O = bus_req & ~ack;
    assign AVS_READDATA_O    = rdata;

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ack   <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            ack <= bus_req & ~ack;
            if (bus_req & ~ack) begin
                rdata <= next_rdata;
            end
        end
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        case (reg_sel)
            `ISR_OFS_MST_REQ: begin
                next_rdata[7:0] = master_req;
            end
            `ISR_OFS_MST_MASK: begin
                next_rdata[7:0] = master_mask;
            end
            `ISR_OFS_SL1_REQ: begin
                next_rdata[7:0] = slave1_req;
            end
            `ISR_OFS_SL1_MASK: begin
                next_rdata[7:0] = slave1_mask;
            end
            `ISR_OFS_SL3_REQ: begin
                next_rdata[7:0] = slave3_req;
            end
            `ISR_OFS_SL3_MASK: begin
                next_rdata[7:0] = slave3_mask;
            end
            `ISR_OFS_FP_CMD: begin
                next_rdata[7:0] = fp_cmd;
            end
            `ISR_OFS_IR_DIS: begin
                next_rdata[7:0] = ir_dis;
            end
            `ISR_OFS_MISC: begin
                next_rdata[7:0] = misc_ctrl;
            end
            `ISR_OFS_SER_CTRL: begin
                next_rdata[7:0] = ser_ctrl;
            end
            `ISR_OFS_SER_IMASK: begin
                next_rdata[7:0] = ser_imask;
            end
            `ISR_OFS_SER_STAT: begin
                next_rdata[7:0] = ser_status;
            end
            `ISR_OFS_RTC_CMD: begin
                next_rdata[7:0] = rtc_cmd;
            end
            `ISR_OFS_RTC_MASK: begin
                next_rdata[7:0] = rtc_mask;
            end
            `ISR_OFS_RTC_STAT: begin
                next_rdata[7:0] = rtc_status;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // ****************************************************************
    // Writable registers
    // ****************************************************************
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            master_mask <= `ISR_RST_MASK;
            slave1_mask <= `ISR_RST_MASK;
            slave3_mask <= `ISR_RST_MASK;
            fp_cmd      <= `ISR_RST_ZERO;
            ir_dis      <= `ISR_RST_IR_DIS;
            misc_ctrl   <= `ISR_RST_ZERO;
            ser_ctrl    <= `ISR_RST_ZERO;
            ser_imask   <= `ISR_RST_ZERO;
            rtc_cmd     <= `ISR_RST_ZERO;
            rtc_mask    <= `ISR_RST_ZERO;
        end else if (wr_en) begin
            case (reg_sel)
                `ISR_OFS_MST_MASK: begin
                    master_mask <= wbyte;
                end
                `ISR_OFS_SL1_MASK: begin
                    slave1_mask <= wbyte;
                end
                `ISR_OFS_SL3_MASK: begin
                    slave3_mask <= wbyte;
                end
                `ISR_OFS_FP_CMD: begin
                    fp_cmd <= wbyte;
                end
                `ISR_OFS_IR_DIS: begin
                    ir_dis <= wbyte;
                end
                `ISR_OFS_MISC: begin
                    misc_ctrl <= wbyte;
                end
                `ISR_OFS_SER_CTRL: begin
                    ser_ctrl <= wbyte;
                end
                `ISR_OFS_SER_IMASK: begin
                    ser_imask <= wbyte;
                end
                `ISR_OFS_RTC_CMD: begin
                    rtc_cmd <= wbyte;
                end
                `ISR_OFS_RTC_MASK: begin
                    rtc_mask <= wbyte;
                end
                default: begin
                    master_mask <= master_mask;
                end
            endcase
        end
    end

    // ****************************************************************
    // Front panel
    // ****************************************************************
    assign INFRARED_LED_OFF_N_O = (ir_dis != `ISR_IR_DIS_OFF);
    // The panel raises its request when its LEDs come back on after being off.
    assign ir_rise = wr_en & (reg_sel == `ISR_OFS_IR_DIS) & ~INFRARED_LED_OFF_N_O
                     & (wbyte != `ISR_IR_DIS_OFF);

    always @* begin
        next_fp_state = fp_state;
        next_fp_count = fp_count;
        fp_clear      = 1'b0;
        if (wr_en & (reg_sel == `ISR_OFS_FP_CMD)) begin
            case (fp_state)
                FP_GOT_A: begin
                    next_fp_state = (wbyte == `ISR_FP_CMD_B) ? FP_GOT_B : FP_IDLE;
                    next_fp_count = 6'h00;
                end
                FP_GOT_B, FP_COUNT: begin
                    if (wbyte == `ISR_FP_CMD_C) begin
                        next_fp_count = fp_count + 6'h01;
                        next_fp_state = FP_COUNT;
                        if (fp_count == (`ISR_FP_CMD_C_COUNT - 6'h01)) begin
                            fp_clear      = 1'b1;
                            next_fp_state = FP_IDLE;
                        end
                    end else begin
                        next_fp_state = FP_IDLE;
                        next_fp_count = 6'h00;
                    end
                end
                default: begin
                    next_fp_state = FP_IDLE;
                    next_fp_count = 6'h00;
                end
            endcase
            // A fresh first command always restarts the sequence.
            if (wbyte == `ISR_FP_CMD_A) begin
                next_fp_state = FP_GOT_A;
                next_fp_count = 6'h00;
            end
        end
    end

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fp_state   <= FP_IDLE;
            fp_count   <= 6'h00;
            fp_pending <= 1'b0;
        end else begin
            fp_state <= next_fp_state;
            fp_count <= next_fp_count;
            if (ir_rise) begin
                fp_pending <= 1'b1;
            end else if (fp_clear) begin
                fp_pending <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Serial link port
    // ****************************************************************
    assign rx_reset = misc_ctrl[`ISR_MISC_BIT_RXRST];
    assign tx_reset = misc_ctrl[`ISR_MISC_BIT_TXRST];
    assign SERIAL_LINK_PORT_RX_RESET_O = rx_reset;
    assign SERIAL_LINK_PORT_TX_RESET_O = tx_reset;
    assign SERIAL_LINK_PORT_LOOPBACK_O = ~ser_ctrl[`ISR_SER_CTRL_NORM];
    // No character path is modelled, so a released transmitter always stands empty.
    assign tx_empty   = ~tx_reset;
    assign ser_events = {ser_ext & {3{~rx_reset}}, tx_empty};
    assign ser_req    = |(ser_events & ser_imask[3:0]);

    assign ser_status = {2'b00,
                         data_back[2],
                         1'b0,
                         data_back[1],
                         1'b0,
                         tx_empty,
                         data_back[0]};

    // ****************************************************************
    // Real-time clock
    // ****************************************************************
    assign tick_run = rtc_cmd[`ISR_RTC_CMD_RUN];

    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tick_count <= 32'h0000_0000;
            tick       <= 1'b0;
        end else if (!tick_run) begin
            tick_count <= 32'h0000_0000;
            tick       <= 1'b0;
        end else if (tick_count == (TICK_CYCLES - 1)) begin
            tick_count <= 32'h0000_0000;
            tick       <= 1'b1;
        end else begin
            tick_count <= tick_count + 32'h0000_0001;
            tick       <= 1'b0;
        end
    end

    // A tick landing on the clearing read survives it.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rtc_status <= 8'h00;
        end else begin
            if (rd_en & (reg_sel == `ISR_OFS_RTC_STAT)) begin
                rtc_status <= 8'h00;
            end
            if (tick) begin
                rtc_status[`ISR_RTC_BIT_HUND] <= 1'b1;
            end
        end
    end

    assign rtc_req = |(rtc_status & rtc_mask);

    // ****************************************************************
    // Cascaded controllers
    // ****************************************************************
    assign slave1_req = {3'b000, ser_req, 4'b0000};
    assign slave3_req = {1'b0, rtc_req, 6'b00_0000};
    assign slave1_out = |(slave1_req & ~slave1_mask);
    assign slave3_out = |(slave3_req & ~slave3_mask);
    assign master_req = {3'b000, fp_pending, slave3_out, 1'b0, slave1_out, 1'b0};
    assign CPU_INT_O  = |(master_req & ~master_mask);

endmodule // isr_top

// [isr_map.vh]
`ifndef ISR_MAP_VH
`define ISR_MAP_VH

// ********
// Register word offsets (address bits 5:2)
// ********
`define ISR_OFS_MST_REQ    4'h0
`define ISR_OFS_MST_MASK   4'h1
`define ISR_OFS_SL1_REQ    4'h2
`define ISR_OFS_SL1_MASK   4'h3
`define ISR_OFS_SL3_REQ    4'h4
`define ISR_OFS_SL3_MASK   4'h5
`define ISR_OFS_FP_CMD     4'h6
`define ISR_OFS_IR_DIS     4'h7
`define ISR_OFS_MISC       4'h8
`define ISR_OFS_SER_CTRL   4'h9
`define ISR_OFS_SER_IMASK  4'hA
`define ISR_OFS_SER_STAT   4'hB
`define ISR_OFS_RTC_CMD    4'hC
`define ISR_OFS_RTC_MASK   4'hD
`define ISR_OFS_RTC_STAT   4'hE

// ********
// Field positions
// ********
`define ISR_MST_BIT_SL1    1
`define ISR_MST_BIT_SL3    3
`define ISR_MST_BIT_FP     4
`define ISR_SL1_BIT_SER    4
`define ISR_SL3_BIT_RTC    6
`define ISR_MISC_BIT_RXRST 3
`define ISR_MISC_BIT_TXRST 4
`define ISR_SER_CTRL_NORM  2
`define ISR_SER_ST_LEFT    5
`define ISR_SER_ST_CENTER  3
`define ISR_SER_ST_TXE     1
`define ISR_SER_ST_RIGHT   0
`define ISR_SER_IM_TXE     0
`define ISR_RTC_CMD_RUN    4
`define ISR_RTC_BIT_HUND   1

// ********
// Command values and reset values
// ********
`define ISR_FP_CMD_A       8'h04
`define ISR_FP_CMD_B       8'h22
`define ISR_FP_CMD_C       8'hE0
`define ISR_FP_CMD_C_COUNT 6'h21
`define ISR_IR_DIS_OFF     8'h00
`define ISR_RST_MASK       8'hFF
`define ISR_RST_IR_DIS     8'h01
`define ISR_RST_ZERO       8'h00

// ********
// Timing
// ********
`define ISR_CLK_KHZ        125000
`define ISR_RTC_TICK_MS    10
`define ISR_RTC_TICK_CYC   (`ISR_CLK_KHZ * `ISR_RTC_TICK_MS)

`endif

// [isr_sync.v]
`timescale 1ns/1ps

module isr_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset.
    input  wire             clk_i,
    input  wire             rst_n_i,
    // Data.
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    reg [WIDTH-1:0] stage3;
    genvar          g;

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
            stage3 <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_i;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit only moves once two settled stages agree, so one bad sample is ignored.
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync_o[g] <= 1'b0;
                end else if (stage2[g] == stage3[g]) begin
                    sync_o[g] <= stage3[g];
                end
            end
        end
    endgenerate

endmodule // isr_sync

// [isr_props.sv]
`timescale 1ns/1ps
`include "isr_map.vh"
// ********
// Port checker
// ********
module isr_props (
    // Clock and reset.
    input wire        CLK_I,
    input wire        RST_N_I,
    // Register bus.
    input wire [5:0]  AVS_ADDRESS_I,
    input wire        AVS_READ_I,
    input wire        AVS_WRITE_I,
    input wire [31:0] AVS_WRITEDATA_I,
    input wire        AVS_WAITREQUEST_O,
    // Pins.
    input wire        SERIAL_LINK_PORT_RX_RESET_O,
    input wire        SERIAL_LINK_PORT_TX_RESET_O,
    input wire        SERIAL_LINK_PORT_LOOPBACK_O,
    input wire        INFRARED_LED_OFF_N_O,
    input wire        CPU_INT_O
);
    wire [3:0] wa  = AVS_ADDRESS_I[5:2];
    wire [7:0] wd  = AVS_WRITEDATA_I[7:0];
    wire       acc = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    wire       rxb = AVS_WRITEDATA_I[`ISR_MISC_BIT_RXRST];
    wire       txb = AVS_WRITEDATA_I[`ISR_MISC_BIT_TXRST];
    wire       nb  = AVS_WRITEDATA_I[`ISR_SER_CTRL_NORM];
    reg        mm_wr;
    // Until the master mask is first written, every source must stay blocked.
    always @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I)
            mm_wr <= 1'b0;
        else if (acc && wa == `ISR_OFS_MST_MASK)
            mm_wr <= 1'b1;
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    chk_led_low : assert property (
        acc && wa == `ISR_OFS_IR_DIS && wd == 8'h00 |=> !INFRARED_LED_OFF_N_O)
        else $error("LED line not low after zero write");
    chk_led_high : assert property (
        acc && wa == `ISR_OFS_IR_DIS && wd != 8'h00 |=> INFRARED_LED_OFF_N_O)
        else $error("LED line not high after nonzero write");
    chk_led_hold : assert property (
        !(acc && wa == `ISR_OFS_IR_DIS) |=> $stable(INFRARED_LED_OFF_N_O))
        else $error("LED line moved without a write");
    chk_rx_reset : assert property (
        acc && wa == `ISR_OFS_MISC |=> SERIAL_LINK_PORT_RX_RESET_O == $past(rxb))
        else $error("receiver reset does not follow latch");
    chk_tx_reset : assert property (
        acc && wa == `ISR_OFS_MISC |=> SERIAL_LINK_PORT_TX_RESET_O == $past(txb))
        else $error("transmitter reset does not follow latch");
    chk_loop_mode : assert property (
        acc && wa == `ISR_OFS_SER_CTRL |=> SERIAL_LINK_PORT_LOOPBACK_O != $past(nb))
        else $error("loopback does not follow control select");
    chk_loop_hold : assert property (
        !(acc && wa == `ISR_OFS_SER_CTRL) |=> $stable(SERIAL_LINK_PORT_LOOPBACK_O))
        else $error("loopback moved without a write");
    chk_mask_all : assert property (
        acc && wa == `ISR_OFS_MST_MASK && wd == 8'hFF |=> !CPU_INT_O)
        else $error("interrupt passes a full master mask");
    chk_int_reset : assert property (
        !mm_wr |-> !CPU_INT_O)
        else $error("interrupt before master mask opened");
    chk_wait_single : assert property (
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("more than one wait cycle");
endmodule // isr_props

bind isr_top isr_props u_props (
    .CLK_I, .RST_N_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WRITEDATA_I,
    .AVS_WAITREQUEST_O, .SERIAL_LINK_PORT_RX_RESET_O, .SERIAL_LINK_PORT_TX_RESET_O,
    .SERIAL_LINK_PORT_LOOPBACK_O, .INFRARED_LED_OFF_N_O, .CPU_INT_O);

// [isr_link_model.sv]
`timescale 1ns/1ps
// ********
// Serial link port far end
// ********
module isr_link_model (
    // Clock and control from the block.
    input  wire       clk_i,
    input  wire       rx_reset_i,
    // Wanted levels from the bench.
    input  wire [2:0] data_back_i,
    input  wire [2:0] event_i,
    // Pins into the block.
    output reg  [2:0] data_back_o = 3'h0,
    output reg  [2:0] event_o = 3'h0
);
    // Outputs are registered, so the pins only move on the rising clock edge.
    always @(posedge clk_i) begin
        data_back_o <= data_back_i;
        event_o     <= rx_reset_i ? 3'h0 : event_i;
    end
endmodule // isr_link_model

// [tb.sv]
`timescale 1ns/1ps
`include "isr_map.vh"
// ********
// Bench
// ********
module tb;
    localparam TICK = 20;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [5:0]  addr = 6'h00;
    reg         rd_en = 1'b0;
    reg         wr_en = 1'b0;
    reg  [31:0] wdata = 32'h0;
    reg  [2:0]  db = 3'h0;
    reg  [2:0]  ev = 3'h0;
    reg  [31:0] got;
    reg  [31:0] rnd;
    wire [31:0] rdata;
    wire [2:0]  db_pin;
    wire [2:0]  ev_pin;
    wire        waitreq;
    wire        rx_rst;
    wire        tx_rst;
    wire        loop;
    wire        led_n;
    wire        cpu_int;
    integer     error_cnt = 0;
    integer     checked = 0;
    integer     seed = 32'h6e6da089;
    integer     mm = 255, s1m = 255, s3m = 255, im = 0, rm = 0;
    integer     misc = 0, ctrl = 0, ir = 1, fp = 0, pc = -1, rs = 0;
    always #4 clk = ~clk;
    isr_top #(.TICK_CYCLES(TICK)) DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
        .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(waitreq), .SERIAL_LINK_PORT_DATA_BACK_I(db_pin),
        .SERIAL_LINK_PORT_EVENT_I(ev_pin), .SERIAL_LINK_PORT_RX_RESET_O(rx_rst),
        .SERIAL_LINK_PORT_TX_RESET_O(tx_rst), .SERIAL_LINK_PORT_LOOPBACK_O(loop),
        .INFRARED_LED_OFF_N_O(led_n), .CPU_INT_O(cpu_int));
    isr_link_model u_link (.clk_i(clk), .rx_reset_i(rx_rst), .data_back_i(db),
        .event_i(ev), .data_back_o(db_pin), .event_o(ev_pin));
    function logic sreq();
        sreq = |({ev & {3{~misc[3]}}, ~misc[4]} & im[3:0]);
    endfunction
    function logic [7:0] mreq();
        mreq = {3'h0, fp[0], |(rs & rm & 255) & ~s3m[6], 1'b0, sreq() & ~s1m[4], 1'b0};
    endfunction
    task miss(input [31:0] g, input [31:0] e);
        begin
            error_cnt = error_cnt + 1;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask
    task cmp_reg(input [31:0] g, input [31:0] e, input [31:0] m);
        begin
            checked = checked + 1;
            if ((g & m) !== (e & m))
                miss(g, e);
        end
    endtask
    task cmp_pins;
        reg [4:0] e;
        begin
            @(negedge clk);
            e = {misc[3], misc[4], ~ctrl[2], ir != 0, |(mreq() & ~mm[7:0])};
            checked = checked + 1;
            if ({rx_rst, tx_rst, loop, led_n, cpu_int} !== e)
                miss({rx_rst, tx_rst, loop, led_n, cpu_int}, e);
            @(posedge clk);
        end
    endtask
    task bus(input rw, input [3:0] ofs, input [7:0] d);
        integer n;
        reg     w;
        begin
            addr <= {ofs, 2'b00};
            wdata <= {24'h0, d};
            wr_en <= rw;
            rd_en <= !rw;
            n = 0;
            w = 1'b1;
            while (w !== 1'b0 && n < 50) begin
                @(negedge clk);
                w = waitreq;
                @(posedge clk);
                n = n + 1;
            end
            got = rdata;
            rd_en <= 1'b0;
            wr_en <= 1'b0;
            if (w !== 1'b0)
                miss(n, 0);
            if (rw) begin
                case (ofs)
                    `ISR_OFS_MST_MASK: mm = d;
                    `ISR_OFS_SL1_MASK: s1m = d;
                    `ISR_OFS_SL3_MASK: s3m = d;
                    `ISR_OFS_SER_IMASK: im = d;
                    `ISR_OFS_SER_CTRL: ctrl = d;
                    `ISR_OFS_MISC: misc = d;
                    `ISR_OFS_RTC_MASK: rm = d;
                    `ISR_OFS_IR_DIS: begin
                        fp = (ir == 0 && d != 0) ? 1 : fp;
                        ir = d;
                    end
                    `ISR_OFS_FP_CMD: begin
                        pc = (d == 8'h04) ? 0 : (pc == 0 && d == 8'h22) ? 1
                            : (pc > 0 && d == 8'hE0) ? pc + 1 : -1;
                        fp = (pc == 34) ? 0 : fp;
                        pc = (pc == 34) ? -1 : pc;
                    end
                    default: ;
                endcase
            end else if (ofs == `ISR_OFS_RTC_STAT)
                rs = 0;
            @(posedge clk);
        end
    endtask
    task rdc(input [3:0] ofs, input [31:0] e, input [31:0] m);
        begin
            bus(1'b0, ofs, 8'h00);
            cmp_reg(got, e, m);
        end
    endtask
    task fp_init(input integer n);
        begin
            bus(1'b1, `ISR_OFS_FP_CMD, 8'h04);
            bus(1'b1, `ISR_OFS_FP_CMD, 8'h22);
            repeat (n) bus(1'b1, `ISR_OFS_FP_CMD, 8'hE0);
        end
    endtask
    task end_sim;
        begin
            $display("checked %0d error_cnt %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        #400000;
        miss(0, 1);
        end_sim;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdc(`ISR_OFS_MST_MASK, 255, 255);
        rdc(`ISR_OFS_SL1_MASK, 255, 255);
        rdc(`ISR_OFS_SL3_MASK, 255, 255);
        rdc(4'hF, 0, 32'hFFFFFFFF);
        cmp_pins;
        $display("test reset done");
        fp_init(33);
        rdc(`ISR_OFS_MST_REQ, mreq(), 8'h1A);
        bus(1'b1, `ISR_OFS_IR_DIS, 8'h00);
        cmp_pins;
        bus(1'b1, `ISR_OFS_IR_DIS, 8'h01);
        cmp_pins;
        rdc(`ISR_OFS_MST_REQ, mreq(), 8'h1A);
        bus(1'b1, `ISR_OFS_MST_MASK, 8'hEF);
        cmp_pins;
        bus(1'b1, `ISR_OFS_MST_MASK, 8'hFF);
        cmp_pins;
        fp_init(32);
        rdc(`ISR_OFS_MST_REQ, mreq(), 8'h1A);
        bus(1'b1, `ISR_OFS_FP_CMD, 8'hE0);
        rdc(`ISR_OFS_MST_REQ, mreq(), 8'h1A);
        $display("test panel done");
        bus(1'b1, `ISR_OFS_MISC, 8'h18);
        cmp_pins;
        bus(1'b1, `ISR_OFS_SER_CTRL, 8'h38);
        bus(1'b1, `ISR_OFS_SER_IMASK, 8'h00);
        bus(1'b1, `ISR_OFS_MISC, 8'h00);
        rnd = $random(seed);
        ev <= rnd[2:0];
        repeat (8) @(posedge clk);
        cmp_pins;
        rdc(`ISR_OFS_SL1_REQ, {sreq(), 4'h0}, 8'h10);
        bus(1'b1, `ISR_OFS_MST_MASK, 8'hFD);
        bus(1'b1, `ISR_OFS_SL1_MASK, 8'hEF);
        cmp_pins;
        bus(1'b1, `ISR_OFS_SER_IMASK, 8'h01);
        cmp_pins;
        rdc(`ISR_OFS_SL1_REQ, {sreq(), 4'h0}, 8'h10);
        rdc(`ISR_OFS_MST_REQ, mreq(), 8'h1A);
        bus(1'b1, `ISR_OFS_SL1_MASK, 8'hFF);
        cmp_pins;
        bus(1'b1, `ISR_OFS_MST_MASK, 8'hFF);
        bus(1'b1, `ISR_OFS_MISC, 8'h18);
        bus(1'b1, `ISR_OFS_SER_CTRL, 8'h3C);
        rnd = $random(seed);
        db <= rnd[2:0];
        repeat (8) @(posedge clk);
        cmp_pins;
        rdc(`ISR_OFS_SER_STAT, {2'h0, db[2], 1'b0, db[1], 1'b0, ~misc[4], db[0]}, 8'h2B);
        bus(1'b1, `ISR_OFS_SER_CTRL, {2'h0, db[0], db[1], db[2], 3'h4});
        bus(1'b1, `ISR_OFS_SER_IMASK, 8'h0E);
        bus(1'b1, `ISR_OFS_MISC, 8'h00);
        rnd = $random(seed);
        ev <= rnd[2:0] | 3'h1;
        repeat (8) @(posedge clk);
        cmp_pins;
        rdc(`ISR_OFS_SL1_REQ, {sreq(), 4'h0}, 8'h10);
        $display("test serial done");
        bus(1'b1, `ISR_OFS_RTC_MASK, 8'h00);
        bus(1'b0, `ISR_OFS_RTC_STAT, 8'h00);
        rdc(`ISR_OFS_SL3_REQ, 0, 8'h40);
        rnd = $random(seed);
        bus(1'b1, `ISR_OFS_SL3_MASK, rnd[7:0]);
        rdc(`ISR_OFS_SL3_MASK, rnd, 255);
        bus(1'b1, `ISR_OFS_SL3_MASK, 8'hBF);
        bus(1'b1, `ISR_OFS_MST_MASK, 8'hF7);
        bus(1'b1, `ISR_OFS_RTC_CMD, 8'h18);
        bus(1'b1, `ISR_OFS_RTC_MASK, 8'h02);
        repeat (TICK + 8) @(posedge clk);
        rs = 2;
        rdc(`ISR_OFS_SL3_REQ, 8'h40, 8'h40);
        cmp_pins;
        bus(1'b1, `ISR_OFS_RTC_CMD, 8'h08);
        rdc(`ISR_OFS_RTC_STAT, 2, 2);
        rdc(`ISR_OFS_RTC_STAT, 0, 2);
        repeat (TICK + 8) @(posedge clk);
        rdc(`ISR_OFS_RTC_STAT, 0, 2);
        cmp_pins;
        $display("test clock done");
        end_sim;
    end
endmodule // tb
